//--- rtl/button_holdoff.v
// power button hold-low timer for off-state entry
`timescale 1ns/10ps
`include "fault_irq_map.vh"
module button_holdoff #(
    parameter HOLD_CYCLES = `HOLDOFF_CYCLES
) (
    input  wire clk_i,
    input  wire reset_i,
    input  wire enable_i,
    input  wire button_i,
    output reg  off_o
);
    reg [31:0] cnt;

    // ==========================================================
    // count cycles while the button stays low
    always @(posedge clk_i) begin
        if (reset_i || !enable_i || button_i) begin
            cnt   <= 32'h00000000;
            off_o <= 1'b0;
        end else if (cnt >= HOLD_CYCLES - 1) begin
            off_o <= 1'b1;
        end else begin
            cnt <= cnt + 32'h00000001;
        end
    end
endmodule

//--- rtl/fault_irq_map.vh
// register offsets, field positions, reset values and timing counts
// Overview of operation
// - ldo bank flag bits 5..0 set on ldo4, ldo3, 3v3, sd, ldo2, ldo1 current limit
// - sticky flags clear only on a written 1; written 0 leaves them
// - mask bit 0 unmasks its flag, 1 masks it
// - every unmasked flag shows on the interrupt pin; masked flags do not
// - ldo mask bits sit at the same positions as their flags
// - sense bits are read-only and follow live conditions
// - ldo sense bit reads 1 while that regulator is over current limit
// - sense bits after reset follow regulator state, no reset constant
// - fuse programming sense bit 6 reads 1 while programming runs
// - misc sense bank: fuse error bit 7, overvoltage bit 2, boost bit 0
// - boost sense bit reads 1 while boost is over current limit
// - status and mask registers are accessible at any time
// - backup cell control bit 3 enables the charger
// - backup cell bits 2:0 select charge voltage 2.50 V to 3.30 V
// - power control at 0x1B holds protect, polarity, delay, debounce, holdoff, restart
// - standby delay inserts 0 to 3 slow-clock periods before standby entry
// - with protection enabled a regulator in current limit is shut down
// - standby polarity 0 means active high pin, 1 active low
// - with holdoff enabled, button low 4 s or more enters off state
`ifndef FAULT_IRQ_MAP_VH
`define FAULT_IRQ_MAP_VH

// ==========================================================
// register word offsets (byte address = index * 4)
`define REG_LDO_FAULT_STATUS   8'h10
`define REG_LDO_FAULT_MASK     8'h11
`define REG_LDO_FAULT_SENSE    8'h12
`define REG_MISC_FAULT_SENSE_B 8'h0F
`define REG_BACKUP_CELL_CTRL   8'h1A
`define REG_POWER_CONTROL      8'h1B

// ==========================================================
// reset values
`define RST_POWER_CONTROL      8'h10
`define RST_LDO_FAULT_MASK     6'h3F
`define RST_BACKUP_CELL_CTRL   4'h0

// ==========================================================
// field positions
`define PC_SHORT_PROTECT       7
`define PC_STANDBY_POL         6
`define PC_STBY_DLY_HI         5
`define PC_STBY_DLY_LO         4
`define PC_DBNC_HI             3
`define PC_DBNC_LO             2
`define PC_HOLDOFF_EN          1
`define PC_RESTART_EN          0
`define BC_CHARGER_EN          3
`define MS_FUSE_ERROR          7
`define MS_FUSE_RUNNING        6
`define MS_OVERVOLTAGE         2
`define MS_BOOST               0
`define UNMAPPED_READ          32'h00000000

// ==========================================================
// timing: clock 250 MHz, holdoff 4 s, slow clock 32768 Hz
`define SYS_CLK_HZ             250000000
`define HOLDOFF_SECONDS        4
`define HOLDOFF_CYCLES         (`HOLDOFF_SECONDS * `SYS_CLK_HZ)
`define SLOW_CLK_HZ            32768
`define SLOW_PERIOD_CYCLES     (`SYS_CLK_HZ / `SLOW_CLK_HZ)

`endif

//--- rtl/regulator_fault_irq_bank.v
// fault interrupt bank, power control and backup cell registers
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "fault_irq_map.vh"
module regulator_fault_irq_bank #(
    parameter HOLD_CYCLES   = `HOLDOFF_CYCLES,
    parameter PERIOD_CYCLES = `SLOW_PERIOD_CYCLES
) (
    input  wire        CLK_SYS_I,
    input  wire        RESET_I,
    // avalon-mm slave
    input  wire [9:0]  AVS_ADDRESS_I,
    input  wire        AVS_READ_I,
    input  wire        AVS_WRITE_I,
    input  wire [31:0] AVS_WRITEDATA_I,
    input  wire [3:0]  AVS_BYTEENABLE_I,
    output reg  [31:0] AVS_READDATA_O,
    output wire        AVS_WAITREQUEST_O,
    // live fault conditions, bit 5..0 = ldo4, ldo3, 3v3, sd, ldo2, ldo1
    input  wire [5:0]  LDO_LIMIT_I,
    input  wire        FUSE_ERROR_I,
    input  wire        FUSE_PROGRAM_RUNNING_I,
    input  wire        SUPPLY_OVERVOLTAGE_I,
    input  wire        BOOST_LIMIT_I,
    input  wire        STANDBY_PIN_I,
    input  wire        POWER_BUTTON_IN_I,
    // outputs
    output wire        IRQ_OUT_N_O,
    output reg  [5:0]  LDO_SHUTDOWN_O,
    output wire        BACKUP_CHARGER_ENABLE_O,
    output wire [2:0]  BACKUP_CHARGE_VOLTAGE_SEL_O,
    output wire [1:0]  BUTTON_DEBOUNCE_SEL_O,
    output wire        AUTO_RESTART_ENABLE_O,
    output wire        STANDBY_ENTER_O,
    output wire        OFF_ENTER_O
);
    reg  [5:0]  ldo_fault_status;
    reg  [5:0]  ldo_fault_mask;
    reg  [3:0]  backup_cell_control;
    reg  [7:0]  power_control;
    reg         ack;
    wire [7:0]  word_idx;
    wire        hit;
    wire        wr_lane0;
    wire [5:0]  clear_bits;
    wire [7:0]  ldo_fault_sense;
    wire [7:0]  misc_fault_sense_b;
    wire        standby_req;

    // ==========================================================
    // bus decode: one wait state per access, write lands when wait drops
    assign word_idx          = AVS_ADDRESS_I[9:2];
    assign hit               = (AVS_READ_I || AVS_WRITE_I) && !ack;
    assign AVS_WAITREQUEST_O = hit;
    assign wr_lane0          = AVS_WRITE_I && ack && AVS_BYTEENABLE_I[0];

    function is_reg;
        input [7:0] idx;
        input [7:0] target;
        begin
            is_reg = (idx == target);
        end
    endfunction

    always @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            ack <= 1'b0;
        end else begin
            ack <= hit;
        end
    end

    // ==========================================================
    // live sense bits, no storage
    assign ldo_fault_sense    = {2'h0, LDO_LIMIT_I};
    assign misc_fault_sense_b = {FUSE_ERROR_I, FUSE_PROGRAM_RUNNING_I, 3'h0,
                                 SUPPLY_OVERVOLTAGE_I, 1'b0, BOOST_LIMIT_I};

    // ==========================================================
    // sticky ldo flags, write one to clear, set wins
    assign clear_bits = (wr_lane0 && is_reg(word_idx, `REG_LDO_FAULT_STATUS)) ?
                        AVS_WRITEDATA_I[5:0] : 6'h00;
    always @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            ldo_fault_status <= 6'h00;
        end else begin
            ldo_fault_status <= (ldo_fault_status & ~clear_bits) | LDO_LIMIT_I;
        end
    end

    // ==========================================================
    // writable control registers
    always @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            ldo_fault_mask      <= `RST_LDO_FAULT_MASK;
            backup_cell_control <= `RST_BACKUP_CELL_CTRL;
            power_control       <= `RST_POWER_CONTROL;
        end else if (wr_lane0) begin
            if (is_reg(word_idx, `REG_LDO_FAULT_MASK))
                ldo_fault_mask <= AVS_WRITEDATA_I[5:0];
            if (is_reg(word_idx, `REG_BACKUP_CELL_CTRL))
                backup_cell_control <= AVS_WRITEDATA_I[3:0];
            if (is_reg(word_idx, `REG_POWER_CONTROL))
                power_control <= AVS_WRITEDATA_I[7:0];
        end
    end

    // ==========================================================
    // read data, registered on the acknowledging edge
    always @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            AVS_READDATA_O <= 32'h00000000;
        end else if (AVS_READ_I && hit) begin
            case (word_idx)
                `REG_LDO_FAULT_STATUS:   AVS_READDATA_O <= {26'h0, ldo_fault_status};
                `REG_LDO_FAULT_MASK:     AVS_READDATA_O <= {26'h0, ldo_fault_mask};
                `REG_LDO_FAULT_SENSE:    AVS_READDATA_O <= {24'h0, ldo_fault_sense};
                `REG_MISC_FAULT_SENSE_B: AVS_READDATA_O <= {24'h0, misc_fault_sense_b};
                `REG_BACKUP_CELL_CTRL:   AVS_READDATA_O <= {28'h0, backup_cell_control};
                `REG_POWER_CONTROL:      AVS_READDATA_O <= {24'h0, power_control};
                default:                 AVS_READDATA_O <= `UNMAPPED_READ;
            endcase
        end
    end

    // ==========================================================
    // interrupt pin, active low
    assign IRQ_OUT_N_O = ~|(ldo_fault_status & ~ldo_fault_mask);

    // ==========================================================
    // short-circuit shutdown, latched until protection disabled or reset
    always @(posedge CLK_SYS_I) begin
        if (RESET_I || !power_control[`PC_SHORT_PROTECT]) begin
            LDO_SHUTDOWN_O <= 6'h00;
        end else begin
            LDO_SHUTDOWN_O <= LDO_SHUTDOWN_O | LDO_LIMIT_I;
        end
    end

    // ==========================================================
    // field outputs
    assign BACKUP_CHARGER_ENABLE_O     = backup_cell_control[`BC_CHARGER_EN];
    assign BACKUP_CHARGE_VOLTAGE_SEL_O = backup_cell_control[2:0];
    assign BUTTON_DEBOUNCE_SEL_O       = power_control[`PC_DBNC_HI:`PC_DBNC_LO];
    assign AUTO_RESTART_ENABLE_O       = power_control[`PC_RESTART_EN];
    assign standby_req = STANDBY_PIN_I ^ power_control[`PC_STANDBY_POL];

    standby_delay #(
        .PERIOD_CYCLES (PERIOD_CYCLES)
    ) u_standby (
        .clk_i       (CLK_SYS_I),
        .reset_i     (RESET_I),
        .request_i   (standby_req),
        .delay_sel_i (power_control[`PC_STBY_DLY_HI:`PC_STBY_DLY_LO]),
        .standby_o   (STANDBY_ENTER_O)
    );

    button_holdoff #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_holdoff (
        .clk_i    (CLK_SYS_I),
        .reset_i  (RESET_I),
        .enable_i (power_control[`PC_HOLDOFF_EN]),
        .button_i (POWER_BUTTON_IN_I),
        .off_o    (OFF_ENTER_O)
    );
endmodule

//--- rtl/standby_delay.v
// standby request delay in slow-clock periods
`timescale 1ns/10ps
`include "fault_irq_map.vh"
module standby_delay #(
    parameter PERIOD_CYCLES = `SLOW_PERIOD_CYCLES
) (
    input  wire       clk_i,
    input  wire       reset_i,
    input  wire       request_i,
    input  wire [1:0] delay_sel_i,
    output reg        standby_o
);
    reg  [31:0] cyc;
    reg  [1:0]  periods;

    // ==========================================================
    // count whole periods while request holds
    always @(posedge clk_i) begin
        if (reset_i || !request_i) begin
            cyc       <= 32'h00000000;
            periods   <= 2'h0;
            standby_o <= 1'b0;
        end else if (periods >= delay_sel_i) begin
            standby_o <= 1'b1;
        end else if (cyc == PERIOD_CYCLES - 1) begin
            cyc     <= 32'h00000000;
            periods <= periods + 2'h1;
        end else begin
            cyc <= cyc + 32'h00000001;
        end
    end
endmodule

//--- test/fault_irq_checker.sv
// port checker for the fault interrupt bank
`timescale 1ns/10ps
module fault_irq_checker #(
    parameter HOLD_CYCLES   = 20,
    parameter PERIOD_CYCLES = 4
) (
    input wire        CLK_SYS_I,
    input wire        RESET_I,
    input wire [9:0]  AVS_ADDRESS_I,
    input wire        AVS_READ_I,
    input wire        AVS_WRITE_I,
    input wire [31:0] AVS_WRITEDATA_I,
    input wire [3:0]  AVS_BYTEENABLE_I,
    input wire [31:0] AVS_READDATA_O,
    input wire        AVS_WAITREQUEST_O,
    input wire [5:0]  LDO_LIMIT_I,
    input wire        FUSE_ERROR_I,
    input wire        FUSE_PROGRAM_RUNNING_I,
    input wire        SUPPLY_OVERVOLTAGE_I,
    input wire        BOOST_LIMIT_I,
    input wire        POWER_BUTTON_IN_I,
    input wire        IRQ_OUT_N_O,
    input wire [5:0]  LDO_SHUTDOWN_O,
    input wire        OFF_ENTER_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RESET_I);
    // any limit seen since reset
    logic seen;
    always @(posedge CLK_SYS_I) seen <= RESET_I ? 1'b0 : (seen | (|LDO_LIMIT_I));
    // flag and mask model built from the bus and the limit inputs
    logic [5:0] m_stat;
    logic [5:0] m_mask;
    wire        m_wr  = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0];
    wire  [5:0] m_clr = (m_wr && AVS_ADDRESS_I[9:2] == 8'h10) ? AVS_WRITEDATA_I[5:0] : 6'h00;
    always @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            m_stat <= 6'h00;
            m_mask <= 6'h3F;
        end else begin
            m_stat <= (m_stat & ~m_clr) | LDO_LIMIT_I;
            if (m_wr && AVS_ADDRESS_I[9:2] == 8'h11)
                m_mask <= AVS_WRITEDATA_I[5:0];
        end
    end
    // ==========================================================
    // bus steps
    sequence s_req_new;
        $rose(AVS_READ_I || AVS_WRITE_I);
    endsequence
    sequence s_rd_done;
        AVS_READ_I && !AVS_WAITREQUEST_O;
    endsequence
    a_reset_values: assert property ($fell(RESET_I) |-> IRQ_OUT_N_O && LDO_SHUTDOWN_O == 6'h00)
        else $error("bad state after reset");
    a_wait_first: assert property (s_req_new |-> AVS_WAITREQUEST_O)
        else $error("no wait in first cycle");
    a_wait_ends: assert property (s_req_new |=> !AVS_WAITREQUEST_O)
        else $error("access not answered");
    a_ldo_sense: assert property (s_rd_done ##0 AVS_ADDRESS_I[9:2] == 8'h12
        |-> AVS_READDATA_O == {26'h0, $past(LDO_LIMIT_I)})
        else $error("ldo sense not live");
    a_misc_sense: assert property (s_rd_done ##0 AVS_ADDRESS_I[9:2] == 8'h0F
        |-> AVS_READDATA_O[7:0] == {$past(FUSE_ERROR_I), $past(FUSE_PROGRAM_RUNNING_I), 3'b000,
        $past(SUPPLY_OVERVOLTAGE_I), 1'b0, $past(BOOST_LIMIT_I)})
        else $error("misc sense wrong");
    a_unmapped_zero: assert property (s_rd_done ##0 AVS_ADDRESS_I[9:2] == 8'h00
        |-> AVS_READDATA_O == 32'h00000000)
        else $error("unmapped read not zero");
    a_shut_cause: assert property (((LDO_SHUTDOWN_O & ~$past(LDO_SHUTDOWN_O)) & ~$past(LDO_LIMIT_I))
        == 6'h00)
        else $error("shutdown without limit");
    a_off_cause: assert property ($rose(OFF_ENTER_O) |-> !$past(POWER_BUTTON_IN_I))
        else $error("off without button");
    a_irq_cause: assert property (!IRQ_OUT_N_O |-> seen)
        else $error("irq without flag");
    a_irq_level: assert property (IRQ_OUT_N_O == ~|(m_stat & ~m_mask))
        else $error("irq level differs from flags");
endmodule
bind regulator_fault_irq_bank fault_irq_checker #(.HOLD_CYCLES(HOLD_CYCLES),
    .PERIOD_CYCLES(PERIOD_CYCLES)) u_chk (.*);

//--- test/fault_irq_host.sv
// host model that counts interrupt pin assertions
`timescale 1ns/10ps
module fault_irq_host (
    input  wire    clk_i,
    input  wire    irq_n_i,
    output integer hits_o
);
    logic last = 1'b1;
    initial hits_o = 0;
    // count each new low level
    always @(posedge clk_i) begin
        if (irq_n_i === 1'b0 && last === 1'b1)
            hits_o <= hits_o + 1;
        last <= irq_n_i;
    end
endmodule

//--- test/tb_regulator_fault_irq_bank.sv
// self-checking bench for the fault interrupt bank
`timescale 1ns/10ps
`include "fault_irq_map.vh"
module tb_regulator_fault_irq_bank;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [9:0]  adr = 10'h000;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic [3:0]  be = 4'h1;
    logic [5:0]  lim = 6'h00;
    logic [3:0]  misc = 4'h0;
    logic        pin = 1'b0;
    logic        btn = 1'b1;
    wire  [31:0] q;
    wire  [5:0]  shut;
    wire  [2:0]  vsel;
    wire  [1:0]  dbnc;
    wire         irq_n, stby, off, wait_o, chen, rs_en;
    integer      n_fail = 0, check_count = 0, hits, k, c;
    regulator_fault_irq_bank #(.HOLD_CYCLES(20), .PERIOD_CYCLES(4)) dut (
        .CLK_SYS_I(clk), .RESET_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be),
        .AVS_READDATA_O(q), .AVS_WAITREQUEST_O(wait_o), .LDO_LIMIT_I(lim),
        .FUSE_ERROR_I(misc[3]), .FUSE_PROGRAM_RUNNING_I(misc[2]),
        .SUPPLY_OVERVOLTAGE_I(misc[1]), .BOOST_LIMIT_I(misc[0]), .STANDBY_PIN_I(pin),
        .POWER_BUTTON_IN_I(btn), .IRQ_OUT_N_O(irq_n), .LDO_SHUTDOWN_O(shut),
        .BACKUP_CHARGER_ENABLE_O(chen), .BACKUP_CHARGE_VOLTAGE_SEL_O(vsel),
        .BUTTON_DEBOUNCE_SEL_O(dbnc), .AUTO_RESTART_ENABLE_O(rs_en),
        .STANDBY_ENTER_O(stby), .OFF_ENTER_O(off));
    fault_irq_host host (.clk_i(clk), .irq_n_i(irq_n), .hits_o(hits));
    // ==========================================================
    // clock and tasks
    initial forever #2 clk = ~clk;
    task chk(input [31:0] got, input [31:0] exp);
        begin
            check_count++;
            if (got !== exp) begin
                n_fail++;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task bus(input logic we, input [7:0] idx, input [7:0] d);
        begin
            adr <= {idx, 2'b00};
            wd <= {24'h0, d};
            rd <= !we;
            wr <= we;
            @(posedge clk);
            while (wait_o !== 1'b0)
                @(posedge clk);
            rdat = q;
            rd <= 1'b0;
            wr <= 1'b0;
            @(posedge clk);
        end
    endtask
    task rchk(input [7:0] idx, input [7:0] exp);
        begin
            bus(1'b0, idx, 8'h00);
            chk(rdat, {24'h0, exp});
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d fails %0d", check_count, n_fail);
            if (n_fail == 0 && check_count > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_sim;
    end
    // ==========================================================
    // tests
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rchk(`REG_POWER_CONTROL, 8'h10);
        rchk(`REG_LDO_FAULT_MASK, 8'h3F);
        rchk(`REG_LDO_FAULT_STATUS, 8'h00);
        bus(1'b1, 8'h00, 8'hFF);
        rchk(8'h00, 8'h00);
        bus(1'b1, `REG_POWER_CONTROL, 8'hAF);
        rchk(`REG_POWER_CONTROL, 8'hAF);
        chk({dbnc, rs_en}, 3'b111);
        be <= 4'hE;
        bus(1'b1, `REG_POWER_CONTROL, 8'h00);
        rchk(`REG_POWER_CONTROL, 8'hAF);
        be <= 4'h1;
        bus(1'b1, `REG_BACKUP_CELL_CTRL, 8'h0D);
        chk({chen, vsel}, 4'hD);
        for (k = 0; k < 6; k++) begin
            lim <= 6'h01 << k;
            rchk(`REG_LDO_FAULT_SENSE, 8'h01 << k);
            lim <= 6'h00;
            rchk(`REG_LDO_FAULT_SENSE, 8'h00);
            chk(shut, (6'h02 << k) - 1);
            bus(1'b1, `REG_LDO_FAULT_STATUS, 8'h00);
            rchk(`REG_LDO_FAULT_STATUS, 8'h01 << k);
            chk(irq_n, 1);
            bus(1'b1, `REG_LDO_FAULT_MASK, 8'h3F ^ (8'h01 << k));
            chk(irq_n, 0);
            bus(1'b1, `REG_LDO_FAULT_MASK, 8'h3F);
            chk(irq_n, 1);
            bus(1'b1, `REG_LDO_FAULT_STATUS, 8'h01 << k);
            rchk(`REG_LDO_FAULT_STATUS, 8'h00);
        end
        chk(hits, 6);
        lim <= 6'h01;
        bus(1'b1, `REG_LDO_FAULT_STATUS, 8'h01);
        rchk(`REG_LDO_FAULT_STATUS, 8'h01);
        lim <= 6'h00;
        bus(1'b1, `REG_LDO_FAULT_STATUS, 8'h3F);
        for (k = 0; k < 4; k++) begin
            misc <= 4'h1 << k;
            rchk(`REG_MISC_FAULT_SENSE_B, k == 0 ? 8'h01 : k == 1 ? 8'h04 : k == 2 ? 8'h40 : 8'h80);
        end
        misc <= 4'h0;
        for (k = 0; k < 4; k++) begin
            bus(1'b1, `REG_POWER_CONTROL, k << 4);
            pin <= 1'b1;
            c = 0;
            while (stby !== 1'b1 && c < 40) begin
                @(negedge clk);
                c++;
            end
            chk(shut, 0);
            chk(c, 4 * k + 2);
            @(posedge clk) pin <= 1'b0;
            repeat (3) @(posedge clk);
        end
        bus(1'b1, `REG_POWER_CONTROL, 8'h40);
        repeat (3) @(negedge clk);
        chk(stby, 1);
        @(posedge clk) pin <= 1'b1;
        repeat (3) @(negedge clk);
        chk(stby, 0);
        bus(1'b1, `REG_POWER_CONTROL, 8'h02);
        btn <= 1'b0;
        repeat (15) @(negedge clk);
        chk(off, 0);
        c = 0;
        while (off !== 1'b1 && c < 20) begin
            @(negedge clk);
            c++;
        end
        chk(off, 1);
        chk(c, 6);
        @(posedge clk) btn <= 1'b1;
        end_sim;
    end
endmodule
